// ### rtl/battery_protect_param_regs.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
// What this block does
// R1 - Locked registers refuse every software write
// R2 - Software locks with two writes, four cycles
// R3 - Lock sets only inside the window
// R4 - Software programs early, then locks
// R5 - Lock covers all five parameter registers
// R6 - Upper nibbles of two registers read zero
// R7 - Deep under-voltage disable masks that condition
// R8 - Short-circuit disable masks short-circuit condition
// R9 - Discharge over-current disable masks that condition
// R10 - Charge over-current disable masks that condition
// R11 - Upper timing nibble sets short-circuit time
// R12 - Lower timing nibble sets over-current time
// R13 - One over-current time serves both directions
// R14 - Upper level nibble: discharge threshold code
// R15 - Lower level nibble: charge threshold code
// R16 - Short-circuit nibble: discharge threshold code
// R17 - Lock bit is bit zero
// R18 - Lock-enable bit is bit one
// R19 - Software spaces rewrites by eight clocks
// R20 - Protection fires after level outlasts time
module battery_protect_param_regs (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic [bp_param_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [bp_param_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire bp_param_pkg::detect_t ABOVE_LEVEL,
    output bp_param_pkg::detect_t PROTECT_ACTIVE,
    output logic [3:0] DISCHARGE_OC_LEVEL,
    output logic [3:0] CHARGE_OC_LEVEL,
    output logic [3:0] SHORT_CIRCUIT_LEVEL,
    output logic [5:0] DEEP_UV_SETTING,
    output logic LOCKED
);
    logic [7:0] disable_ctrl;
    logic [7:0] timing;
    logic [7:0] oc_level;
    logic [7:0] sc_level;
    logic [7:0] deep_uv;
    bp_param_pkg::lock_state_t lock_state;
    logic [2:0] window;
    logic [bp_param_pkg::ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic aw_held;
    logic w_held;
    logic wr_fire;
    logic wr_hit;
    bp_param_pkg::detect_t above_meta;
    bp_param_pkg::detect_t above_sync;
    logic [bp_param_pkg::TIME_W-1:0] sc_limit;
    logic [bp_param_pkg::TIME_W-1:0] oc_limit;

    // Word index of a byte address; returns 8'hff for misaligned or far
    // Upper address bits must be zero, else the map would repeat above
    function automatic logic [7:0] word_index(
        input logic [bp_param_pkg::ADDR_W-1:0] a);
        word_index = (a[1:0] == 2'h0 && a[bp_param_pkg::ADDR_W-1:10] == '0)
            ? a[9:2] : 8'hff;
    endfunction

    // Mapped index test, shared by both channels
    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == bp_param_pkg::IDX_TIMING)
            || (i == bp_param_pkg::IDX_DEEP_UV)
            || (i == bp_param_pkg::IDX_LOCK)
            || (i == bp_param_pkg::IDX_DISABLE)
            || (i == bp_param_pkg::IDX_OC_LEVEL)
            || (i == bp_param_pkg::IDX_SC_LEVEL);
    endfunction

    // Address and data are caught separately, in either order; ready
    // drops while frozen so no handshake is seen that the state misses
    assign AWREADY = CLK_EN && !aw_held && !BVALID;
    assign WREADY = CLK_EN && !w_held && !BVALID;
    assign wr_fire = aw_held && w_held && !BVALID;
    assign wr_hit = wr_fire && w_lane0
        && (lock_state != bp_param_pkg::LOCK_SET); // [R1]

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= bp_param_pkg::RESET_VALUE;
            w_lane0 <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (AWVALID && AWREADY)
            begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (WVALID && WREADY)
            begin
                w_held <= 1'b1;
                w_data <= WDATA[7:0];
                w_lane0 <= WSTRB[0];
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            BVALID <= 1'b0;
            BRESP <= bp_param_pkg::RESP_OKAY;
        end
        else if (CLK_EN)
        begin
            if (wr_fire)
            begin
                BVALID <= 1'b1;
                BRESP <= is_mapped(word_index(aw_addr))
                    ? bp_param_pkg::RESP_OKAY : bp_param_pkg::RESP_SLVERR;
            end
            else if (BREADY)
                BVALID <= 1'b0;
        end
    end

    // Reserved upper bits are masked on entry, so they read zero
    // Parameter registers; refused silently once locked
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            disable_ctrl <= bp_param_pkg::RESET_VALUE;
            timing <= bp_param_pkg::RESET_VALUE;
            oc_level <= bp_param_pkg::RESET_VALUE;
            sc_level <= bp_param_pkg::RESET_VALUE;
            deep_uv <= bp_param_pkg::RESET_VALUE;
        end
        else if (CLK_EN && wr_hit) // [R5]
        begin
            case (word_index(aw_addr))
                bp_param_pkg::IDX_DISABLE:
                    disable_ctrl <= w_data & bp_param_pkg::MASK_DISABLE;
                bp_param_pkg::IDX_TIMING:
                    timing <= w_data;
                bp_param_pkg::IDX_OC_LEVEL:
                    oc_level <= w_data;
                bp_param_pkg::IDX_SC_LEVEL:
                    sc_level <= w_data & bp_param_pkg::MASK_SC_LEVEL; // [R6]
                bp_param_pkg::IDX_DEEP_UV:
                    deep_uv <= w_data & bp_param_pkg::MASK_DEEP_UV;
                default:
                    ;
            endcase
        end
    end

    // Lock sequence; a stray write inside the window disarms it
    // Window counts CPU clocks from the commit of the arming write
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            lock_state <= bp_param_pkg::LOCK_IDLE;
            window <= 3'h0;
        end
        else if (CLK_EN)
        begin
            case (lock_state)
                bp_param_pkg::LOCK_IDLE:
                    if (wr_hit
                        && word_index(aw_addr) == bp_param_pkg::IDX_LOCK
                        && w_data[bp_param_pkg::LOCK_EN_BIT] // [R18]
                        && w_data[bp_param_pkg::LOCK_BIT]) // [R17]
                    begin
                        lock_state <= bp_param_pkg::LOCK_ARMED;
                        window <= bp_param_pkg::LOCK_WINDOW;
                    end
                bp_param_pkg::LOCK_ARMED:
                    if (wr_hit
                        && word_index(aw_addr) == bp_param_pkg::IDX_LOCK
                        && !w_data[bp_param_pkg::LOCK_EN_BIT]
                        && w_data[bp_param_pkg::LOCK_BIT])
                        lock_state <= bp_param_pkg::LOCK_SET; // [R3]
                    else if (window == 3'h1 || wr_hit)
                        lock_state <= bp_param_pkg::LOCK_IDLE; // [R3]
                    else
                        window <= window - 3'h1;
                bp_param_pkg::LOCK_SET:
                    lock_state <= bp_param_pkg::LOCK_SET; // [R1]
                default:
                    lock_state <= bp_param_pkg::LOCK_IDLE;
            endcase
        end
    end

    // Read channel; one cycle latency, held until RREADY
    // Reads pass the lock; only writes are refused
    assign ARREADY = CLK_EN && !RVALID;

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= bp_param_pkg::RESP_OKAY;
        end
        else if (CLK_EN)
        begin
            if (ARVALID && ARREADY)
            begin
                RVALID <= 1'b1;
                RRESP <= is_mapped(word_index(ARADDR))
                    ? bp_param_pkg::RESP_OKAY : bp_param_pkg::RESP_SLVERR;
                case (word_index(ARADDR))
                    bp_param_pkg::IDX_DISABLE:
                        RDATA <= {24'h000000, disable_ctrl}; // [R6]
                    bp_param_pkg::IDX_TIMING:
                        RDATA <= {24'h000000, timing};
                    bp_param_pkg::IDX_OC_LEVEL:
                        RDATA <= {24'h000000, oc_level};
                    bp_param_pkg::IDX_SC_LEVEL:
                        RDATA <= {24'h000000, sc_level}; // [R6]
                    bp_param_pkg::IDX_DEEP_UV:
                        RDATA <= {24'h000000, deep_uv};
                    bp_param_pkg::IDX_LOCK:
                        RDATA <= {31'h0000_0000,
                            lock_state == bp_param_pkg::LOCK_SET};
                    default:
                        RDATA <= 32'h0000_0000;
                endcase
            end
            else if (RREADY)
                RVALID <= 1'b0;
        end
    end

    // Threshold codes go straight to the analog comparators
    assign DISCHARGE_OC_LEVEL = oc_level[7:4]; // [R14]
    assign CHARGE_OC_LEVEL = oc_level[3:0]; // [R15]
    assign SHORT_CIRCUIT_LEVEL = sc_level[3:0]; // [R16]
    assign DEEP_UV_SETTING = deep_uv[5:0];
    assign LOCKED = (lock_state == bp_param_pkg::LOCK_SET);

    // Comparator outputs are asynchronous: two flops first
    // Frozen with the rest while the clock enable is low
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            above_meta <= '0;
            above_sync <= '0;
        end
        else if (CLK_EN)
        begin
            above_meta <= ABOVE_LEVEL;
            above_sync <= above_meta;
        end
    end

    // Short-circuit: 61us steps to code 7, then 122us steps
    always_comb
    begin
        if (!timing[7])
            sc_limit = bp_param_pkg::TIME_W'((32'(timing[6:4]) + 32'd1)
                * bp_param_pkg::SC_STEP_CYC); // [R11]
        else
            sc_limit = bp_param_pkg::TIME_W'((32'(timing[6:4]) * 32'd2
                + 32'd10) * bp_param_pkg::SC_STEP_CYC); // [R11]
    end

    // Over-current: 1 ms for code 0, else 2 ms per code step
    always_comb
    begin
        if (timing[3:0] == 4'h0)
            oc_limit = bp_param_pkg::TIME_W'(bp_param_pkg::OC_STEP_CYC);
        else
            oc_limit = bp_param_pkg::TIME_W'(32'(timing[3:0]) * 32'd2
                * bp_param_pkg::OC_STEP_CYC); // [R12]
    end

    // One persistence timer per protection; deep under-voltage
    // delay is timed elsewhere, here it is only gated
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_prot
            logic [bp_param_pkg::TIME_W-1:0] cnt;
            logic [bp_param_pkg::TIME_W-1:0] lim;
            logic dis;
            logic act;
            assign dis = disable_ctrl[g]; // [R7] [R8] [R9] [R10]
            // One flop per bit, so each output bit has a single writer
            assign PROTECT_ACTIVE[g] = act;
            assign lim = (g == bp_param_pkg::SC_DIS_BIT) ? sc_limit
                : (g == bp_param_pkg::DUV_DIS_BIT)
                ? '0 : oc_limit; // [R13]
            always_ff @(posedge MCLK)
            begin
                if (RESET)
                begin
                    cnt <= '0;
                    act <= 1'b0;
                end
                else if (CLK_EN)
                begin
                    if (dis || !above_sync[g])
                    begin
                        cnt <= '0;
                        act <= 1'b0;
                    end
                    else if (cnt >= lim)
                        act <= 1'b1; // [R20]
                    else
                        cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate
endmodule

// ### rtl/bp_param_pkg.sv
package bp_param_pkg;
    // Printed offsets; 0xf6 is not a multiple of four, so the
    // map keeps every offset as an index and the byte address is 4x it
    localparam logic [7:0] IDX_TIMING = 8'hf6;
    localparam logic [7:0] IDX_DEEP_UV = 8'hf3;
    localparam logic [7:0] IDX_LOCK = 8'hf0;
    localparam logic [7:0] IDX_DISABLE = 8'hf1;
    localparam logic [7:0] IDX_OC_LEVEL = 8'hf4;
    localparam logic [7:0] IDX_SC_LEVEL = 8'hf5;
    localparam int ADDR_W = 12;

    // Field positions
    localparam int LOCK_BIT = 0;
    localparam int LOCK_EN_BIT = 1;
    localparam int DUV_DIS_BIT = 3;
    localparam int SC_DIS_BIT = 2;
    localparam int DOC_DIS_BIT = 1;
    localparam int COC_DIS_BIT = 0;

    // Masks of implemented bits; reserved bits read zero
    localparam logic [7:0] MASK_DISABLE = 8'h0f;
    localparam logic [7:0] MASK_SC_LEVEL = 8'h0f;
    localparam logic [7:0] MASK_DEEP_UV = 8'h3f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // Lock window length in CPU clocks
    localparam logic [2:0] LOCK_WINDOW = 3'h4;

    // Reaction time steps
    localparam int CLK_MHZ = 20;
    localparam int SC_STEP_US = 61;
    localparam int OC_STEP_MS = 1;
    localparam int SC_STEP_CYC = SC_STEP_US * CLK_MHZ;
    localparam int OC_STEP_CYC = OC_STEP_MS * 1000 * CLK_MHZ;
    localparam int TIME_W = 20;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Detector inputs and protection activations
    typedef struct packed {
        logic deep_uv;
        logic short_circuit;
        logic discharge_oc;
        logic charge_oc;
    } detect_t;

    typedef enum {LOCK_IDLE, LOCK_ARMED, LOCK_SET} lock_state_t;
endpackage

// ### sim/battery_protect_param_regs_test.sv
`timescale 1ns/100ps
// Random and corner register traffic, protection timing and lock
module battery_protect_param_regs_test;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic CLK_EN = 1'b1;
    logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
    logic BREADY = 1'b1, RREADY = 1'b1; // Answers always taken at once
    logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hf;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LOCKED;
    logic [1:0] BRESP, RRESP, rs;
    logic [31:0] RDATA, rd;
    logic [3:0] DISCHARGE_OC_LEVEL, CHARGE_OC_LEVEL, SHORT_CIRCUIT_LEVEL;
    logic [5:0] DEEP_UV_SETTING;
    bp_param_pkg::detect_t ABOVE_LEVEL = 4'h0;
    bp_param_pkg::detect_t PROTECT_ACTIVE;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic lk = 1'b0;
    logic [31:0] lfsr = 32'h0bdd;
    // Disable, deep UV, OC level, SC level, timing
    logic [7:0] ix [5] = '{8'hf1, 8'hf3, 8'hf4, 8'hf5, 8'hf6};
    logic [7:0] mk [5] = '{8'h0f, 8'h3f, 8'hff, 8'h0f, 8'hff};
    logic [7:0] sh [5] = '{default: 8'h00};

    battery_protect_param_regs dut (.MCLK(MCLK), .RESET(RESET),
        .CLK_EN(CLK_EN), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .ABOVE_LEVEL(ABOVE_LEVEL), .PROTECT_ACTIVE(PROTECT_ACTIVE),
        .DISCHARGE_OC_LEVEL(DISCHARGE_OC_LEVEL),
        .CHARGE_OC_LEVEL(CHARGE_OC_LEVEL),
        .SHORT_CIRCUIT_LEVEL(SHORT_CIRCUIT_LEVEL),
        .DEEP_UV_SETTING(DEEP_UV_SETTING), .LOCKED(LOCKED));

    always #25 MCLK = ~MCLK;

    // Hang guard, well above the longest timer run
    always @(posedge MCLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [11:0] ba(logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    // Read value: reserved bits always zero
    function automatic logic [31:0] ex(int k, logic [7:0] v);
        return {24'h0, v & mk[k]};
    endfunction

    task automatic ck(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Ready is sampled at the falling edge, so the bench acts on the
    // same rising edge the slave uses and never races it
    task automatic wr(logic [11:0] a, logic [7:0] d);
        logic ta, tw, tb;
        AWADDR <= a;
        WDATA <= {24'h0, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge MCLK);
            ta = AWREADY;
            tw = WREADY;
            tb = BVALID;
            rs = BRESP;
            @(posedge MCLK);
            if (ta) AWVALID <= 1'b0;
            if (tw) WVALID <= 1'b0;
        end
    endtask

    task automatic rdr(logic [11:0] a);
        logic ta, tg;
        ARADDR <= a;
        ARVALID <= 1'b1;
        tg = 1'b0;
        while (!tg)
        begin
            @(negedge MCLK);
            ta = ARREADY;
            tg = RVALID;
            rd = RDATA;
            rs = RRESP;
            @(posedge MCLK);
            if (ta) ARVALID <= 1'b0;
        end
    endtask

    // Parameter write, spaced for the slow domain to catch up
    task automatic wp(int k, logic [7:0] d);
        wr(ba(ix[k]), d);
        ck("write resp", bp_param_pkg::RESP_OKAY, rs);
        if (!lk) sh[k] = d;
        repeat (8) @(posedge MCLK);
    endtask

    task automatic chk_all();
        for (int k = 0; k < 5; k++)
        begin
            rdr(ba(ix[k]));
            ck("readback", ex(k, sh[k]), rd);
            ck("read resp", bp_param_pkg::RESP_OKAY, rs);
        end
        ck("dis level", {28'h0, sh[2][7:4]},
            {28'h0, DISCHARGE_OC_LEVEL});
        ck("chg level", {28'h0, sh[2][3:0]},
            {28'h0, CHARGE_OC_LEVEL});
        ck("sc level", {28'h0, sh[3][3:0]},
            {28'h0, SHORT_CIRCUIT_LEVEL});
        ck("duv", {26'h0, sh[1][5:0]}, {26'h0, DEEP_UV_SETTING});
    endtask

    // Outputs are looked at once settled, then back on the rising edge
    task automatic ckp(logic [3:0] e);
        @(negedge MCLK);
        ck("protect", {28'h0, e}, {28'h0, PROTECT_ACTIVE});
        @(posedge MCLK);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge MCLK);
        RESET <= 1'b0;
        chk_all();
        repeat (16)
        begin
            lfsr = step(lfsr);
            wp(int'(lfsr[11:8]) % 5, lfsr[7:0]);
        end
        for (int k = 0; k < 5; k++) wp(k, 8'hff);
        // Write without the low byte lane is dropped but answered
        WSTRB <= 4'he;
        wr(ba(8'hf6), 8'h12);
        WSTRB <= 4'hf;
        ck("no lane resp", bp_param_pkg::RESP_OKAY, rs);
        chk_all();
        rdr(12'h040);
        ck("unmapped resp", bp_param_pkg::RESP_SLVERR, rs);
        ck("unmapped data", 32'h0, rd);
        rdr(ba(8'hf6) + 12'h001);
        ck("misaligned resp", bp_param_pkg::RESP_SLVERR, rs);
        rdr(12'hbd8);
        ck("alias resp", bp_param_pkg::RESP_SLVERR, rs);
        wr(12'h044, 8'h5a);
        ck("unmapped write", bp_param_pkg::RESP_SLVERR, rs);
        // Shortest codes: short 1220 cycles, over-current 20000 cycles
        wp(4, 8'h00);
        wp(0, 8'h00);
        ABOVE_LEVEL <= 4'hf;
        repeat (6) @(posedge MCLK);
        ckp(4'h8);
        repeat (1200) @(posedge MCLK);
        ckp(4'h8);
        repeat (40) @(posedge MCLK);
        ckp(4'hc);
        repeat (18740) @(posedge MCLK);
        ckp(4'hc);
        repeat (60) @(posedge MCLK);
        ckp(4'hf);
        wp(0, 8'h0f);
        ckp(4'h0);
        wp(0, 8'h07);
        ckp(4'h8);
        wp(0, 8'h0b);
        // Frozen cycles must not count toward the reaction time
        CLK_EN <= 1'b0;
        repeat (100) @(posedge MCLK);
        CLK_EN <= 1'b1;
        repeat (1140) @(posedge MCLK);
        ckp(4'h0);
        repeat (100) @(posedge MCLK);
        ckp(4'h4);
        ABOVE_LEVEL <= 4'h0;
        // Second write one cycle past the window, then on its last cycle
        wr(ba(8'hf0), 8'h03);
        repeat (2) @(posedge MCLK);
        wr(ba(8'hf0), 8'h01);
        ck("late lock", 32'h0, {31'h0, LOCKED});
        wr(ba(8'hf0), 8'h03);
        @(posedge MCLK);
        wr(ba(8'hf0), 8'h01);
        lk = 1'b1;
        ck("lock", 32'h1, {31'h0, LOCKED});
        rdr(ba(8'hf0));
        ck("lock bit", 32'h1, rd);
        for (int k = 0; k < 5; k++) wp(k, 8'ha5);
        chk_all();
        wr(ba(8'hf0), 8'h00);
        ck("still locked", 32'h1, {31'h0, LOCKED});
        RESET <= 1'b1;
        repeat (2) @(posedge MCLK);
        RESET <= 1'b0;
        lk = 1'b0;
        sh = '{default: 8'h00};
        ck("unlocked", 32'h0, {31'h0, LOCKED});
        chk_all();
        finish_test();
    end
endmodule

// ### sim/bp_regs_asserts.sv
`timescale 1ns/100ps
// Port-level checks of bus answers, lock and protection release
module bp_regs_asserts (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic AWREADY,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic [1:0] BRESP,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire bp_param_pkg::detect_t ABOVE_LEVEL,
    input wire bp_param_pkg::detect_t PROTECT_ACTIVE,
    input wire logic LOCKED
);
    // Frozen cycles say nothing about timing, so they are skipped
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET || !CLK_EN);

    // Bus answers
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer missing one cycle after address");
    a_read_busy: assert property (RVALID |-> !ARREADY)
        else $error("read address taken while answer pending");
    a_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while response pending");
    a_rdata_upper: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_slverr_zero: assert property (RVALID &&
        RRESP == bp_param_pkg::RESP_SLVERR |-> RDATA == 32'h0)
        else $error("error read returned data");
    a_bresp_legal: assert property (BVALID |->
        BRESP == bp_param_pkg::RESP_OKAY ||
        BRESP == bp_param_pkg::RESP_SLVERR)
        else $error("write response code illegal");

    // Lock and protection release
    a_lock_sticky: assert property (LOCKED |=> LOCKED)
        else $error("lock dropped without reset");
    a_release_coc: assert property ((!ABOVE_LEVEL.charge_oc) [*4]
        |-> !PROTECT_ACTIVE.charge_oc)
        else $error("charge protection held without level");
    a_release_sc: assert property ((!ABOVE_LEVEL.short_circuit) [*4]
        |-> !PROTECT_ACTIVE.short_circuit)
        else $error("short protection held without level");
endmodule

bind battery_protect_param_regs bp_regs_asserts chk (.MCLK(MCLK),
    .RESET(RESET), .CLK_EN(CLK_EN), .AWREADY(AWREADY), .WREADY(WREADY),
    .BVALID(BVALID), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RVALID(RVALID), .RDATA(RDATA), .RRESP(RRESP),
    .ABOVE_LEVEL(ABOVE_LEVEL), .PROTECT_ACTIVE(PROTECT_ACTIVE),
    .LOCKED(LOCKED));
